// ### rtl/crc16_byte_calculator.sv
// crc16_byte_calculator: byte-serial ccitt crc engine with a seedable result.
// assumes writes come from a core or transfer engine as one-cycle strobes on clock.
`timescale 1ns/1ps
`default_nettype none
module crc16_byte_calculator (
  input  wire logic                         clock,
  input  wire logic                         reset,
  input  wire logic                         result_wr,
  input  wire logic [crc16_pkg::CRC_WIDTH-1:0]  result_wdata,
  input  wire logic                         byte_wr,
  input  wire logic [crc16_pkg::DATA_WIDTH-1:0] byte_wdata,
  output logic      [crc16_pkg::CRC_WIDTH-1:0]  crc_result_reg,
  output logic                              busy
);
  import crc16_pkg::*;

  // how the strobes play out, E being the edge that takes a strobe:
  //   byte alone       E holds the byte, E+1 registers the folded code
  //   bytes in a row   each edge holds the next byte and lands the last
  //   seed alone       E replaces the remainder and its view at once
  //   seed while busy  the fold that would land at E is thrown away
  //   seed with byte   E seeds, E+1 lands the byte folded into the seed
  // busy is high exactly in the cycle between E and E+1 of each byte
  // limitation: only the reversed view leaves the block; the remainder in
  // division order is internal, so a seed does not read back as written

  // control state
  fold_state_t                 state_q;
  fold_state_t                 state_d;

  // byte held for the fold cycle
  logic [DATA_WIDTH-1:0]       in_byte_q;
  logic [DATA_WIDTH-1:0]       in_byte_d;

  // running remainder, kept in division order
  logic [CRC_WIDTH-1:0]        rem_q;
  logic [CRC_WIDTH-1:0]        rem_d;

  // reversed copy that the outside world reads
  logic [CRC_WIDTH-1:0]        rd_q;
  logic [CRC_WIDTH-1:0]        rd_d;

  // decoded strobes and the datapath between the registers
  logic                        seed_take;
  logic                        byte_take;
  logic                        fold_now;
  logic                        drop_fold;
  logic [DATA_WIDTH-1:0]       rev_byte;
  logic [CRC_WIDTH-1:0]        folded;

  // loop indices for the wiring-only reversals
  genvar                       gi;
  genvar                       gj;

  // write decode; both strobes may be high on the same edge
  assign seed_take = result_wr;
  assign byte_take = byte_wr;
  assign fold_now  = (state_q == ST_FOLD);
  assign drop_fold = seed_take && !byte_take;

  // reverse bit order within the held byte
  // pure wiring, so bit 0 of the written byte enters the divider first
  generate
    for (gi = 0; gi < DATA_WIDTH; gi++) begin : g_rev_byte
      assign rev_byte[gi] = in_byte_q[DATA_WIDTH-1-gi];
    end
  endgenerate

  crc16_fold u_fold (
    .rem_in  (rem_q),
    .byte_in (rev_byte),
    .rem_out (folded)
  );

  // control next state; the split into a hold cycle and a fold cycle keeps
  // the eight-stage xor chain off the write path at 250 MHz
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (byte_take) begin
          state_d = ST_FOLD;
        end
      end
      ST_FOLD: begin
        if (byte_take) begin
          state_d = ST_FOLD; // back-to-back bytes keep streaming
        end else begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE; // illegal code, recover quietly
      end
    endcase
    if (drop_fold) begin
      state_d = ST_IDLE;
    end
  end

  // control register
  always_ff @(posedge clock) begin
    if (reset) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // held byte next value; a new byte may land while the last one folds
  always_comb begin
    in_byte_d = in_byte_q;
    if (byte_take) begin
      in_byte_d = byte_wdata;
    end
  end

  // held byte register
  always_ff @(posedge clock) begin
    if (reset) begin
      in_byte_q <= BYTE_RESET;
    end else begin
      in_byte_q <= in_byte_d;
    end
  end

  // remainder next value; a seed overrides even a fold that lands on the
  // same edge, so a new block never inherits a half-finished code
  always_comb begin
    case (state_q)
      ST_IDLE: begin
        rem_d = rem_q;
      end
      ST_FOLD: begin
        rem_d = folded;
      end
      default: begin
        rem_d = rem_q;
      end
    endcase
    if (seed_take) begin
      rem_d = result_wdata; // stored as written, not reversed
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      rem_q <= CRC_RESET;
    end else begin
      rem_q <= rem_d;
    end
  end

  // reversed read view
  // taken from the next remainder so the view never lags a cycle behind
  generate
    for (gj = 0; gj < CRC_WIDTH; gj++) begin : g_read_view
      assign rd_d[gj] = rem_d[CRC_WIDTH-1-gj];
    end
  endgenerate

  // read view register; data outputs leave the block from flops
  always_ff @(posedge clock) begin
    if (reset) begin
      rd_q <= CRC_RESET; // reversed zero is still zero
    end else begin
      rd_q <= rd_d;
    end
  end

  // outputs: view from its flops, busy straight from the control state
  assign crc_result_reg = rd_q;
  assign busy           = fold_now;

endmodule : crc16_byte_calculator
`default_nettype wire

// ### rtl/crc16_pkg.sv
// crc16_pkg: constants and types shared by the byte-wise crc calculator.
// assumes a single synchronous clock domain and a synchronous active-high reset.
package crc16_pkg;

  localparam int unsigned CRC_WIDTH  = 16;
  localparam int unsigned DATA_WIDTH = 8;

  // generator bits below x16: x12 + x5 + 1
  localparam logic [15:0] CRC_POLY   = 16'h1021;
  localparam logic [15:0] CRC_RESET  = 16'h0000;
  localparam logic [7:0]  BYTE_RESET = 8'h00;

  // cycles from byte write to settled result
  localparam int unsigned FOLD_CYCLES = 2;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_FOLD = 2'b10
  } fold_state_t;

endpackage : crc16_pkg

// ### rtl/crc16_fold.sv
// crc16_fold: combinational fold of one byte into a sixteen-bit remainder.
// assumes the caller registers the result; pure logic, no state.
`timescale 1ns/1ps
`default_nettype none
module crc16_fold (
  input  wire logic [15:0] rem_in,
  input  wire logic [7:0]  byte_in,
  output logic      [15:0] rem_out
);
  import crc16_pkg::*;

  // bitwise long division, msb of the byte first
  always_comb begin
    logic [15:0] r;
    r = rem_in;
    for (int i = 7; i >= 0; i--) begin
      if (r[15] ^ byte_in[i]) begin
        r = {r[14:0], 1'b0} ^ CRC_POLY;
      end else begin
        r = {r[14:0], 1'b0};
      end
    end
    rem_out = r;
  end

endmodule : crc16_fold
`default_nettype wire

// ### verification/crc16_properties.sv
// checker for the byte-wise crc calculator ports
// assumes one clock and a synchronous reset
`timescale 1ns/1ps
`default_nettype none
module crc16_properties (
  input wire logic        clock,
  input wire logic        reset,
  input wire logic        result_wr,
  input wire logic [15:0] result_wdata,
  input wire logic        byte_wr,
  input wire logic [7:0]  byte_wdata,
  input wire logic [15:0] crc_result_reg,
  input wire logic        busy
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  // reference bit reversal for the read view
  function automatic logic [15:0] flip16(input logic [15:0] v);
    logic [15:0] f;
    for (int i = 0; i < 16; i++) begin
      f[i] = v[15-i];
    end
    return f;
  endfunction : flip16
  a_seed_view: assert property (result_wr |=>
    crc_result_reg == flip16($past(result_wdata)))
    else $error("seed readback wrong");
  a_seed_wins: assert property (result_wr && busy |=>
    crc_result_reg == flip16($past(result_wdata)))
    else $error("seed lost to fold");
  a_byte_busy: assert property (byte_wr && !result_wr |=> busy)
    else $error("no busy after byte");
  a_busy_cause: assert property (busy |-> $past(byte_wr))
    else $error("busy without byte");
  a_busy_once: assert property (byte_wr ##1 !byte_wr |-> busy ##1 !busy)
    else $error("busy length wrong");
  a_hold_idle: assert property (!result_wr && !busy |=> $stable(crc_result_reg))
    else $error("result moved while idle");
  a_first_fold: assert property (result_wr && !byte_wr && result_wdata == 16'h0000 ##1 byte_wr &&
    byte_wdata == 8'h01 && !result_wr ##1 !result_wr |=> crc_result_reg == 16'h1189)
    else $error("single byte code wrong");
  a_two_bytes: assert property (result_wr && !byte_wr && result_wdata == 16'h0000 ##1 byte_wr &&
    byte_wdata == 8'h01 && !result_wr ##1 byte_wr && byte_wdata == 8'h23 && !result_wr
    ##1 !result_wr |=> crc_result_reg == 16'h0A41) else $error("two byte code wrong");
  cover property (result_wr && busy);
  cover property (byte_wr ##1 byte_wr);
  cover property (busy ##1 !busy);
  cover property (result_wr && byte_wr && busy);
endmodule : crc16_properties
`default_nettype wire

// ### verification/testbench.sv
// self-checking bench for the crc calculator, inputs moved on falling edges
// assumes the design package and checker are compiled first
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        clock = 0, reset = 1, result_wr = 0, byte_wr = 0, busy;
  logic [15:0] result_wdata = '0, crc_result_reg;
  logic [7:0]  byte_wdata = '0;
  int          err_total = 0, checked = 0;
  always #2 clock = ~clock;
  crc16_byte_calculator i_dut (.clock, .reset, .result_wr, .result_wdata, .byte_wr,
    .byte_wdata, .crc_result_reg, .busy);
  task automatic cmp(input string n, input logic [15:0] e, g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : cmp
  task automatic cmp_flag(input string n, input logic e, g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s expected %b seen %b", n, e, g);
    end
  endtask : cmp_flag
  // one cycle of strobes, set just after a falling edge
  task automatic drive(input logic r, input logic [15:0] s, input logic b, input logic [7:0] d);
    @(negedge clock);
    {result_wr, result_wdata, byte_wr, byte_wdata} = {r, s, b, d};
  endtask : drive
  task automatic idle(input int n);
    repeat (n) drive(0, '0, 0, '0);
  endtask : idle
  // seed, one byte, then a second byte after and back to back
  task automatic t_bytes;
    drive(1, 16'h0000, 0, '0);
    drive(0, '0, 1, 8'h01);
    idle(3);
    cmp("one byte", 16'h1189, crc_result_reg);
    drive(0, '0, 1, 8'h23);
    idle(3);
    cmp("two bytes", 16'h0A41, crc_result_reg);
    drive(1, 16'h0000, 0, '0);
    drive(0, '0, 1, 8'h01);
    drive(0, '0, 1, 8'h23);
    idle(3);
    cmp("back to back", 16'h0A41, crc_result_reg);
  endtask : t_bytes
  // seed lands on the edge where a fold completes
  task automatic t_override;
    drive(0, '0, 1, 8'h01);
    drive(1, 16'h1234, 0, '0);
    cmp_flag("busy at seed", 1'h1, busy);
    idle(1);
    cmp_flag("busy dropped", 1'h0, busy);
    idle(1);
    cmp("override", 16'h2C48, crc_result_reg);
  endtask : t_override
  // seed and byte on one edge, while another byte is still folding
  task automatic t_same_edge;
    drive(0, '0, 1, 8'hFF);
    drive(1, 16'h0000, 1, 8'h01);
    idle(3);
    cmp("seed with byte", 16'h1189, crc_result_reg);
  endtask : t_same_edge
  task automatic conclude;
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : conclude
  initial begin
    repeat (6) @(negedge clock);
    reset = 0;
    t_bytes();
    t_override();
    t_same_edge();
    conclude();
  end
  // the tests need about 30 cycles
  initial begin
    #2000;
    err_total++;
    conclude();
  end
endmodule : testbench
bind crc16_byte_calculator crc16_properties u_props (.clock, .reset, .result_wr,
  .result_wdata, .byte_wr, .byte_wdata, .crc_result_reg, .busy);
`default_nettype wire
